/* hw/mtc_map.vh */
/*
 * constants for the measurement trigger controller: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz module clock and a plain address/strobe register port.
 */
`ifndef MTC_MAP_VH
`define MTC_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define MTC_ADDR_CMD      8'h00
`define MTC_ADDR_SRC      8'h04
`define MTC_ADDR_TRGCNT   8'h08
`define MTC_ADDR_SMPCNT   8'h0c
`define MTC_ADDR_DELAY    8'h10
`define MTC_ADDR_STATE    8'h14
`define MTC_ADDR_IRQ_STAT 8'h18
`define MTC_ADDR_IRQ_MASK 8'h1c
`define MTC_ADDR_SRC_NAME 8'h20

// ****************************************
// command register bits (write-only pulses)
// ****************************************
`define MTC_CMD_INIT  0
`define MTC_CMD_READ  1
`define MTC_CMD_MEAS  2
`define MTC_CMD_CONF  3
`define MTC_CMD_TRG   4
`define MTC_CMD_GET   5
`define MTC_CMD_ABORT 6

// ****************************************
// trigger source codes
// ****************************************
`define MTC_SRC_IMM  4'h0
`define MTC_SRC_BUS  4'h1
`define MTC_SRC_EXT  4'h2
`define MTC_SRC_LINE 4'h8

// ****************************************
// status / interrupt bit positions
// ****************************************
`define MTC_IRQ_CONFLICT 0
`define MTC_IRQ_TRIGGER  1
`define MTC_IRQ_DONE     2
`define MTC_IRQ_REFUSED  3

// ****************************************
// reset values and limits
// ****************************************
`define MTC_TRGCNT_RST 16'h0001
`define MTC_TRGCNT_MAX 16'hc350
`define MTC_SMPCNT_RST 16'h0001
`define MTC_DELAY_RST  24'h000000

// ****************************************
// timing
// ****************************************
`define MTC_CLK_MHZ     100
`define MTC_SETUP_MS    20
`define MTC_SETUP_CYC   (`MTC_SETUP_MS * 1000 * `MTC_CLK_MHZ)

`endif

/* hw/mtc_edge_det.v */
/*
 * two-flop synchroniser and falling edge detector for one trigger input.
 * assumes the input may be asynchronous to ref_clk; edges wider than two
 * clock periods are seen exactly once.
 */
module mtc_edge_det (
   input wire ref_clk,
   input wire rst_n,
   input wire din,
   output wire fall
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   // ****************************************
   // synchroniser and edge detection
   // ****************************************
   // idle-high lines, so reset to one
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // one pulse per falling edge
   assign fall = last_q & ~sync_q;
endmodule // mtc_edge_det

/* hw/mtc_pace.v */
/*
 * reading pacer: per accepted trigger, waits the trigger delay, then issues
 * sample-count reading strobes, each after the delay.
 * assumes start only arrives while busy is low.
 */
module mtc_pace (
   input wire ref_clk,
   input wire rst_n,
   input wire start,
   input wire abort,
   input wire [15:0] samples,
   input wire [23:0] delay,
   output reg reading,
   output wire busy
);
   reg [15:0] left_q;
   reg [23:0] wait_q;

   // ****************************************
   // delay then reading strobe, repeated
   // ****************************************
   always @(posedge ref_clk) begin
      if (!rst_n || abort) begin
         left_q <= 16'h0000;
         wait_q <= 24'h000000;
         reading <= 1'b0;
      end else begin
         reading <= 1'b0;
         if (start) begin
            left_q <= samples;
            wait_q <= delay;
         end else if (left_q != 16'h0000) begin
            if (wait_q != 24'h000000) begin
               wait_q <= wait_q - 24'h000001;
            end else begin
               reading <= 1'b1;
               left_q <= left_q - 16'h0001;
               wait_q <= delay;
            end
         end
      end
   end

   assign busy = (left_q != 16'h0000);
endmodule // mtc_pace

/* hw/mtc_trigger_ctl.v */
/*
 * measurement trigger controller: source select, idle / wait-for-trigger
 * machine, trigger, sample count and delay, register port and interrupt.
 * status bits are sticky and cleared by writing ones to them.
 * assumes a synchronous host register port with one-cycle strobes and
 * read data in the following cycle.
 */
//
// Summary of operation
// - measurements start on command, backplane line or external falling edges.
// - trigger count, samples per trigger and trigger delay are programmable.
// - two states; idle for setup, triggers accepted only in wait state.
// - read-query or cmd_a command moves idle to wait state.
// - cmd_b command always uses the immediate trigger.
// - bus mode triggers on group trigger if last listener, or addressed trigger.
// - external mode triggers on falling edge of external input.
// - immediate mode triggers as soon as the setup time after entering wait state has passed.
// - cmd_b or configure resets source to immediate.
// - backplane line mode triggers on falling edge of chosen line 0..7.
// - source change in wait state is refused and flags settings conflict.
// - source query returns short name string of present source.
// - trigger count 1..50000; return to idle after that many; cmds set 1.
// - triggers ignored for 20 ms after entering wait state.
// - addressed trigger refused unless in wait state.
//
`include "mtc_map.vh"

module mtc_trigger_ctl #(
   parameter SETUP_CYC = `MTC_SETUP_CYC
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata_q,
   input wire [7:0] backplane_trigger_lines,
   input wire ext_trig_n,
   input wire last_listener,
   output reg reading_q,
   output reg waiting_q,
   output reg irq_q
);
   // ****************************************
   // states
   // ****************************************
   // one-hot state codes
   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;

   // machine, configuration, counters and status
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] src_q;
   reg [15:0] trgcnt_q;
   reg [15:0] smpcnt_q;
   reg [23:0] delay_q;
   reg [15:0] accepted_q;
   reg [24:0] setup_q;
   reg [3:0] stat_q;
   reg [3:0] mask_q;
   reg meas_q;
   wire [7:0] line_fall;
   wire ext_fall;
   wire pace_reading;
   wire pace_busy;
   reg trig_hit;
   reg [3:0] ev;
   wire in_wait;
   wire setup_busy;
   wire [15:0] count_limit;
   wire [15:0] pace_samples;

   // ****************************************
   // command decode helpers
   // ****************************************
   function is_cmd;
      input [7:0] a;
      input w;
      input [31:0] d;
      input integer b;
      begin
         is_cmd = w && (a == `MTC_ADDR_CMD) && d[b];
      end
   endfunction

   // source name as four ascii characters
   function [31:0] src_name;
      input [3:0] s;
      begin
         case (s)
            `MTC_SRC_IMM: src_name = 32'h494d4d20;
            `MTC_SRC_BUS: src_name = 32'h42555320;
            `MTC_SRC_EXT: src_name = 32'h45585420;
            default: src_name = {24'h54544c, 5'h06, s[2:0]};
         endcase
      end
   endfunction

   // source code for a written value; bit 3 picks a line, else bit 1 external, else bit 0 bus, else immediate
   function [3:0] src_code;
      input [3:0] d;
      begin
         if (d[3]) begin
            src_code = {1'b1, d[2:0]};
         end else if (d[1]) begin
            src_code = `MTC_SRC_EXT;
         end else if (d[0]) begin
            src_code = `MTC_SRC_BUS;
         end else begin
            src_code = `MTC_SRC_IMM;
         end
      end
   endfunction

   // one-cycle command strobes from the command register
   wire c_init = is_cmd(addr, wr, wdata, `MTC_CMD_INIT);
   wire c_read = is_cmd(addr, wr, wdata, `MTC_CMD_READ);
   wire c_meas = is_cmd(addr, wr, wdata, `MTC_CMD_MEAS);
   wire c_conf = is_cmd(addr, wr, wdata, `MTC_CMD_CONF);
   wire c_trg = is_cmd(addr, wr, wdata, `MTC_CMD_TRG);
   wire c_get = is_cmd(addr, wr, wdata, `MTC_CMD_GET);
   wire c_abort = is_cmd(addr, wr, wdata, `MTC_CMD_ABORT);
   // arming commands and the source register write
   wire arm = c_init | c_read | c_meas;
   wire src_wr = wr && (addr == `MTC_ADDR_SRC);

   // shorthands shared by the machine, the pacer and the status logic
   assign in_wait = (state_q == ST_WAIT);
   assign setup_busy = (setup_q != 25'd0);
   // a cmd_b run takes one trigger and one reading
   assign count_limit = meas_q ? 16'h0001 : trgcnt_q;
   assign pace_samples = meas_q ? 16'h0001 : smpcnt_q;

   // ****************************************
   // input synchronisers
   // ****************************************
   // one synchroniser and edge detector per backplane line
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_line
         mtc_edge_det u_line (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .din(backplane_trigger_lines[gi]),
            .fall(line_fall[gi])
         );
      end
   endgenerate

   // external input, idle high
   mtc_edge_det u_ext (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(ext_trig_n),
      .fall(ext_fall)
   );

   // ****************************************
   // trigger qualification
   // ****************************************
   // cmd_b forces immediate regardless of source
   always @* begin
      trig_hit = 1'b0;
      if (in_wait && !setup_busy && !pace_busy) begin
         if (meas_q) begin
            trig_hit = 1'b1;
         end else begin
            case (src_q)
               `MTC_SRC_IMM: trig_hit = 1'b1;
               `MTC_SRC_BUS: trig_hit = c_trg | (c_get & last_listener);
               `MTC_SRC_EXT: trig_hit = ext_fall;
               default: trig_hit = line_fall[src_q[2:0]];
            endcase
         end
      end
   end

   // ****************************************
   // state machine
   // ****************************************
   // idle to wait on arming, back on abort or on the last trigger
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (arm) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (c_abort) begin
               state_d = ST_IDLE;
            end else if (trig_hit && (accepted_q + 16'h0001 >= count_limit)) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // ****************************************
   // state, counters and setup timer
   // ****************************************
   // arming clears the count and starts the blind time
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         accepted_q <= 16'h0000;
         setup_q <= 25'd0;
         meas_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE && arm) begin
            accepted_q <= 16'h0000;
            setup_q <= SETUP_CYC[24:0];
            meas_q <= c_meas;
         end else begin
            if (setup_busy) begin
               setup_q <= setup_q - 25'd1;
            end
            if (trig_hit) begin
               accepted_q <= accepted_q + 16'h0001;
            end
         end
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   // settings only change in idle
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         src_q <= `MTC_SRC_IMM;
         trgcnt_q <= `MTC_TRGCNT_RST;
         smpcnt_q <= `MTC_SMPCNT_RST;
         delay_q <= `MTC_DELAY_RST;
      end else if ((c_meas | c_conf) && state_q == ST_IDLE) begin
         src_q <= `MTC_SRC_IMM;
         trgcnt_q <= `MTC_TRGCNT_RST;
      end else if (state_q == ST_IDLE && wr) begin
         if (addr == `MTC_ADDR_SRC) begin
            src_q <= src_code(wdata[3:0]);
         end
         if (addr == `MTC_ADDR_TRGCNT) begin
            if (wdata[15:0] == 16'h0000) begin
               trgcnt_q <= 16'h0001;
            end else if (wdata[31:16] != 16'h0000) begin
               trgcnt_q <= `MTC_TRGCNT_MAX; // upper bits set: over the limit
            end else if (wdata[15:0] > `MTC_TRGCNT_MAX) begin
               trgcnt_q <= `MTC_TRGCNT_MAX;
            end else begin
               trgcnt_q <= wdata[15:0];
            end
         end
         if (addr == `MTC_ADDR_SMPCNT) begin
            smpcnt_q <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
         end
         if (addr == `MTC_ADDR_DELAY) begin
            delay_q <= wdata[23:0];
         end
      end
   end

   // ****************************************
   // reading pacer
   // ****************************************
   // delay and reading strobes per accepted trigger
   mtc_pace u_pace (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(trig_hit),
      .abort(c_abort),
      .samples(pace_samples),
      .delay(delay_q),
      .reading(pace_reading),
      .busy(pace_busy)
   );

   // ****************************************
   // interrupt status, mask and output
   // ****************************************
   // set wins over write-one-to-clear
   always @* begin
      ev = 4'h0;
      ev[`MTC_IRQ_CONFLICT] = src_wr && in_wait;
      ev[`MTC_IRQ_TRIGGER] = trig_hit;
      ev[`MTC_IRQ_DONE] = in_wait && state_d == ST_IDLE;
      ev[`MTC_IRQ_REFUSED] = c_trg && !in_wait;
   end

   // sticky status, mask and registered interrupt level
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         stat_q <= 4'h0;
         mask_q <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         if (wr && addr == `MTC_ADDR_IRQ_STAT) begin
            stat_q <= (stat_q & ~wdata[3:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
         if (wr && addr == `MTC_ADDR_IRQ_MASK) begin
            mask_q <= wdata[3:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   // ****************************************
   // outputs and read port
   // ****************************************
   // read data stand only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
         reading_q <= 1'b0;
         waiting_q <= 1'b0;
      end else begin
         reading_q <= pace_reading;
         waiting_q <= (state_d == ST_WAIT);
         rdata_q <= 32'h00000000;
         if (rd) begin
            case (addr)
               `MTC_ADDR_SRC: rdata_q <= {28'h0000000, src_q};
               `MTC_ADDR_TRGCNT: rdata_q <= {16'h0000, trgcnt_q};
               `MTC_ADDR_SMPCNT: rdata_q <= {16'h0000, smpcnt_q};
               `MTC_ADDR_DELAY: rdata_q <= {8'h00, delay_q};
               `MTC_ADDR_STATE: rdata_q <= {accepted_q, 13'h0000, setup_q != 25'd0,
                     pace_busy, state_q == ST_WAIT};
               `MTC_ADDR_IRQ_STAT: rdata_q <= {28'h0000000, stat_q};
               `MTC_ADDR_IRQ_MASK: rdata_q <= {28'h0000000, mask_q};
               `MTC_ADDR_SRC_NAME: rdata_q <= src_name(src_q);
               default: rdata_q <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // mtc_trigger_ctl

/* sim/mtc_trigger_ctl_monitor.sv */
/* checker on the trigger controller ports, bound to the top module.
   assumes one clock, synchronous active low reset, mask in bits 3:0. */
module mtc_trigger_ctl_monitor #(
   parameter SETUP_CYC = 20
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata_q,
   input wire reading_q,
   input wire waiting_q,
   input wire irq_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] mask_q;
   int blind_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // mirror of the mask and cycles spent waiting
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         mask_q <= 4'h0;
      end else if (wr && addr == 8'h1c) begin
         mask_q <= wdata[3:0];
      end
      if (!rst_n || !waiting_q) begin
         blind_q <= 0;
      end else if (blind_q < SETUP_CYC) begin
         blind_q <= blind_q + 1;
      end
   end
   a_rdata_quiet: assert property (rdata_q != 32'h0 |-> $past(rd))
      else $error("read data without read strobe");
   a_wait_cause: assert property ($rose(waiting_q) |-> $past(wr) && $past(addr) == 8'h00)
      else $error("wait state entered without command");
   a_init_arms: assert property (wr && addr == 8'h00 && wdata[1:0] != 2'b00 && !waiting_q
      |=> waiting_q)
      else $error("arm command did not enter wait state");
   a_meas_arms: assert property (wr && addr == 8'h00 && wdata[2] && !waiting_q |=> waiting_q)
      else $error("cmd_b command did not enter wait state");
   a_setup_blind: assert property (reading_q && waiting_q |-> blind_q == SETUP_CYC)
      else $error("reading inside setup time");
   a_conflict_flag: assert property (wr && addr == 8'h04 && waiting_q && mask_q[0]
      |-> ##[1:2] irq_q)
      else $error("source change in wait not flagged");
   a_refuse_flag: assert property (wr && addr == 8'h00 && wdata[4] && !waiting_q && mask_q[3]
      |-> ##[1:2] irq_q)
      else $error("addressed trigger in idle not flagged");
   a_irq_masked: assert property (mask_q == 4'h0 |=> !irq_q)
      else $error("interrupt while all masked");
endmodule // mtc_trigger_ctl_monitor

bind mtc_trigger_ctl mtc_trigger_ctl_monitor #(.SETUP_CYC(SETUP_CYC)) i_mtc_trigger_ctl_monitor (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata_q(rdata_q),
   .reading_q(reading_q),
   .waiting_q(waiting_q),
   .irq_q(irq_q)
);

/* sim/mtc_trig_src.sv */
/* far-side trigger equipment: external input and backplane line drivers.
   assumes lines idle high through pull-ups; tasks are called by the bench. */
module mtc_trig_src (
   input wire ref_clk,
   output logic ext_trig_n,
   output logic [7:0] backplane_trigger_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PULSE_CYC = 120; // 1.2 us low at 100 MHz
   // released lines rest high
   initial begin
      ext_trig_n = 1'b1;
      backplane_trigger_lines = 8'hff;
   end
   // low-going pulse on the external input
   task automatic pulse_ext();
      @(posedge ref_clk);
      ext_trig_n <= 1'b0;
      repeat (PULSE_CYC) @(posedge ref_clk);
      ext_trig_n <= 1'b1;
   endtask
   // low-going pulse on one backplane line
   task automatic pulse_line(input int n);
      @(posedge ref_clk);
      backplane_trigger_lines <= ~(8'h01 << n);
      repeat (PULSE_CYC) @(posedge ref_clk);
      backplane_trigger_lines <= 8'hff;
   endtask
endmodule // mtc_trig_src

/* sim/mtc_trigger_ctl_tb_top.sv */
/* self-checking bench for the trigger controller.
   assumes the design files and mtc_map.vh are on the include path. */
`include "mtc_map.vh"
`define CHK(name, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("ERROR %s expected %h seen %h", name, exp, got); \
      end \
   end
module mtc_trigger_ctl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SETUP = 20;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic last_listener = 1'b0;
   wire [31:0] rdata_q;
   wire ext_trig_n;
   wire [7:0] lines;
   wire reading_q;
   wire waiting_q;
   wire irq_q;
   int mismatches = 0;
   int n_checks = 0;
   int n_read = 0;
   logic [31:0] rv;
   mtc_trigger_ctl #(.SETUP_CYC(SETUP)) i_mtc_trigger_ctl (.ref_clk(ref_clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
      .backplane_trigger_lines(lines), .ext_trig_n(ext_trig_n), .last_listener(last_listener),
      .reading_q(reading_q), .waiting_q(waiting_q), .irq_q(irq_q));
   mtc_trig_src i_mtc_trig_src (.ref_clk(ref_clk), .ext_trig_n(ext_trig_n),
      .backplane_trigger_lines(lines));
   // clock and reading counter
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (reading_q === 1'b1) n_read++;
   end
   // ****************************************
   // bus cycles and helpers
   // ****************************************
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      rv = rdata_q;
   endtask
   task automatic cmd(input int b);
      wr_reg(`MTC_ADDR_CMD, 32'h1 << b);
   endtask
   task automatic setup_wait();
      repeat (SETUP + 10) @(posedge ref_clk);
   endtask
   task automatic wait_idle();
      int i;
      i = 0;
      #1;
      while (waiting_q !== 1'b0 && i < 2000) begin
         @(posedge ref_clk);
         i++;
      end
      `CHK("idle reached", 1'b0, waiting_q)
      repeat (40) @(posedge ref_clk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_imm();
      wr_reg(`MTC_ADDR_SMPCNT, 32'h2);
      wr_reg(`MTC_ADDR_DELAY, 32'h5);
      n_read = 0;
      cmd(`MTC_CMD_INIT);
      @(posedge ref_clk);
      `CHK("armed", 1'b1, waiting_q)
      wait_idle();
      `CHK("imm readings", 2, n_read)
      rd_reg(`MTC_ADDR_IRQ_STAT);
      `CHK("imm status", (32'h1 << `MTC_IRQ_TRIGGER) | (32'h1 << `MTC_IRQ_DONE), rv)
      wr_reg(`MTC_ADDR_IRQ_STAT, 32'hf);
      wr_reg(`MTC_ADDR_SMPCNT, 32'h1);
      wr_reg(`MTC_ADDR_DELAY, 32'h0);
   endtask
   task automatic t_ext();
      wr_reg(`MTC_ADDR_SRC, {28'h0, `MTC_SRC_EXT});
      wr_reg(`MTC_ADDR_TRGCNT, 32'h2);
      rd_reg(`MTC_ADDR_SRC_NAME);
      `CHK("ext name", 32'h45585420, rv)
      n_read = 0;
      cmd(`MTC_CMD_INIT);
      wr_reg(`MTC_ADDR_SRC, {28'h0, `MTC_SRC_BUS});
      rd_reg(`MTC_ADDR_SRC);
      `CHK("src kept", 32'h2, rv)
      rd_reg(`MTC_ADDR_IRQ_STAT);
      `CHK("conflict bit", 1'b1, rv[`MTC_IRQ_CONFLICT])
      `CHK("irq raised", 1'b1, irq_q)
      wr_reg(`MTC_ADDR_IRQ_STAT, 32'hf);
      setup_wait();
      i_mtc_trig_src.pulse_ext();
      `CHK("ext one reading", 1, n_read)
      i_mtc_trig_src.pulse_ext();
      wait_idle();
      `CHK("ext two readings", 2, n_read)
   endtask
   task automatic t_bus();
      cmd(`MTC_CMD_TRG);
      rd_reg(`MTC_ADDR_IRQ_STAT);
      `CHK("refused bit", 1'b1, rv[`MTC_IRQ_REFUSED])
      wr_reg(`MTC_ADDR_IRQ_STAT, 32'hf);
      wr_reg(`MTC_ADDR_SRC, {28'h0, `MTC_SRC_BUS});
      n_read = 0;
      cmd(`MTC_CMD_INIT);
      setup_wait();
      cmd(`MTC_CMD_GET);
      repeat (10) @(posedge ref_clk);
      `CHK("get not listener", 0, n_read)
      last_listener <= 1'b1;
      cmd(`MTC_CMD_GET);
      repeat (10) @(posedge ref_clk);
      `CHK("get listener", 1, n_read)
      last_listener <= 1'b0;
      cmd(`MTC_CMD_TRG);
      wait_idle();
      `CHK("addressed trigger", 2, n_read)
   endtask
   task automatic t_lines();
      wr_reg(`MTC_ADDR_TRGCNT, 32'h1);
      for (int n = 0; n < 8; n++) begin
         wr_reg(`MTC_ADDR_SRC, 32'h8 + n);
         rd_reg(`MTC_ADDR_SRC_NAME);
         `CHK("line name", {24'h54544c, 8'h30 + 8'(n)}, rv)
         n_read = 0;
         cmd(`MTC_CMD_INIT);
         setup_wait();
         i_mtc_trig_src.pulse_line((n + 1) % 8);
         `CHK("other line", 0, n_read)
         i_mtc_trig_src.pulse_line(n);
         wait_idle();
         `CHK("own line", 1, n_read)
      end
   endtask
   task automatic t_meas();
      wr_reg(`MTC_ADDR_SRC, {28'h0, `MTC_SRC_EXT});
      wr_reg(`MTC_ADDR_TRGCNT, 32'h3);
      n_read = 0;
      cmd(`MTC_CMD_MEAS);
      wait_idle();
      `CHK("meas reading", 1, n_read)
      rd_reg(`MTC_ADDR_SRC);
      `CHK("meas source", 32'h0, rv)
      rd_reg(`MTC_ADDR_TRGCNT);
      `CHK("meas count", 32'h1, rv)
      wr_reg(`MTC_ADDR_SRC, {28'h0, `MTC_SRC_EXT});
      cmd(`MTC_CMD_CONF);
      rd_reg(`MTC_ADDR_SRC);
      `CHK("conf source", 32'h0, rv)
   endtask
   task automatic t_misc();
      n_read = 0;
      cmd(`MTC_CMD_INIT);
      rd_reg(`MTC_ADDR_STATE);
      `CHK("state armed", 32'h5, rv)
      cmd(`MTC_CMD_ABORT);
      wait_idle();
      `CHK("abort no reading", 0, n_read)
      wr_reg(`MTC_ADDR_TRGCNT, 32'h0);
      rd_reg(`MTC_ADDR_TRGCNT);
      `CHK("count floor", 32'h1, rv)
      wr_reg(`MTC_ADDR_TRGCNT, 32'h10005);
      rd_reg(`MTC_ADDR_TRGCNT);
      `CHK("count ceiling", {16'h0000, `MTC_TRGCNT_MAX}, rv)
      wr_reg(`MTC_ADDR_TRGCNT, 32'h1);
      cmd(`MTC_CMD_TRG);
      wr_reg(`MTC_ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      `CHK("irq masked", 1'b0, irq_q)
      wr_reg(`MTC_ADDR_IRQ_MASK, 32'hf);
      repeat (2) @(posedge ref_clk);
      `CHK("irq unmasked", 1'b1, irq_q)
      wr_reg(`MTC_ADDR_IRQ_STAT, 32'hf);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_reg(`MTC_ADDR_SRC_NAME);
      `CHK("reset name", 32'h494d4d20, rv)
      wr_reg(`MTC_ADDR_IRQ_MASK, 32'hf);
      t_imm();
      t_ext();
      t_bus();
      t_lines();
      t_meas();
      t_misc();
      finish_test();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end
endmodule // mtc_trigger_ctl_tb_top
